// ---- rtl/amap_map.svh ----
// Offsets, field positions, reset values and counts of the address map block
`ifndef AMAP_MAP_SVH
`define AMAP_MAP_SVH

// ============================================================
// Register bus map (byte address = four times the register index)
`define MAP_REG_INDEX     7'h3D
`define MAP_BYTE_ADDR     9'h0F4
`define STAT_BYTE_ADDR    9'h100
`define MAP_RESET         8'h00

// ============================================================
// Field positions of the placement register
`define RAM_POS_MSB       7
`define RAM_POS_LSB       4
`define REG_POS_MSB       3
`define REG_POS_LSB       0

// ============================================================
// Status register bits
`define STAT_WRITTEN_BIT  0
`define STAT_OPEN_BIT     1
`define STAT_SPECIAL_BIT  2

// ============================================================
// Address space layout
`define REG_BLOCK_SPAN    12'h080
`define RAM_SPLIT         12'h300
`define RAM_RELOC_END     12'h37F
`define RAM_BYTES         768

// ============================================================
// Write window after reset, in clock cycles
`define WRITE_WINDOW_CYC  7'h40

`endif

// ---- rtl/amap_pkg.sv ----
// Types shared by the address map block
package amap_pkg;
    typedef logic [3:0] page_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// ---- rtl/decode_if.sv ----
// Signals between the placement logic and the address decoder
`timescale 1ns/1ps
interface decode_if;
    logic [15:0] cpu_addr;
    logic [3:0]  ram_pos;
    logic [3:0]  reg_pos;
    logic        ram_hit;
    logic [9:0]  ram_index;
    logic        reg_hit;
    logic [6:0]  reg_offset;

    modport dec (input cpu_addr, ram_pos, reg_pos,
                 output ram_hit, ram_index, reg_hit, reg_offset);
    modport top (output cpu_addr, ram_pos, reg_pos,
                 input ram_hit, ram_index, reg_hit, reg_offset);
endinterface

// ---- rtl/map_decoder.sv ----
// Combinational decode of CPU addresses into RAM and register block
`timescale 1ns/1ps
`include "amap_map.svh"
module map_decoder
    import amap_pkg::*;
(
    decode_if.dec d
);
    // ============================================================
    // Address split
    logic [11:0] off;
    logic [11:0] reloc;
    page_t       page;
    logic        ram_page;
    logic        shared;

    assign off    = d.cpu_addr[11:0];
    assign page   = d.cpu_addr[15:12];
    assign reloc  = off - `RAM_SPLIT;
    assign shared = (d.ram_pos == d.reg_pos);

    // Register block wins, RAM takes what is left
    always_comb begin
        d.reg_hit    = (page == d.reg_pos) && (off < `REG_BLOCK_SPAN);
        d.reg_offset = off[6:0];
        ram_page     = (page == d.ram_pos);
        d.ram_hit    = 1'b0;
        d.ram_index  = 10'h000;
        if (!d.reg_hit && ram_page) begin
            if (off < `RAM_SPLIT) begin
                d.ram_hit   = 1'b1;
                d.ram_index = off[9:0];
            end else if (shared && off <= `RAM_RELOC_END) begin
                d.ram_hit   = 1'b1;
                d.ram_index = reloc[9:0];
            end
        end
    end
endmodule

// ---- rtl/ram_reg_map.sv ----
// RAM and register block placement with 768-byte RAM and bus slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "amap_map.svh"
module ram_reg_map
    import amap_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        mode_special,
    input  wire logic [8:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_write,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_ram_hit,
    output logic             cpu_reg_hit,
    output logic      [6:0]  cpu_reg_offset
);
    // ============================================================
    // State
    logic [7:0]  map_r;
    logic [7:0]  map_nxt;
    logic        written_r;
    logic        written_nxt;
    logic [6:0]  cnt_r;
    logic [6:0]  cnt_nxt;
    bus_state_t  bus_state_r;
    bus_state_t  bus_state_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [7:0]  cpu_rdata_r;
    logic [7:0]  cpu_rdata_nxt;
    logic [7:0]  mem [`RAM_BYTES];

    logic        win_open;
    logic        allow;
    logic        avs_map_wr;
    logic        cpu_map_wr;
    logic        map_acc;
    logic [31:0] status;

    decode_if dif ();

    // ============================================================
    // Address decoder
    assign dif.cpu_addr = cpu_addr;
    assign dif.ram_pos  = map_r[`RAM_POS_MSB:`RAM_POS_LSB];
    assign dif.reg_pos  = map_r[`REG_POS_MSB:`REG_POS_LSB];

    map_decoder u_dec (
        .d (dif.dec)
    );

    assign cpu_ram_hit    = dif.ram_hit;
    assign cpu_reg_hit    = dif.reg_hit;
    assign cpu_reg_offset = dif.reg_offset;

    // ============================================================
    // Placement register write gate
    assign win_open   = cnt_r < `WRITE_WINDOW_CYC;
    assign allow      = mode_special || (!written_r && win_open);
    assign avs_map_wr = (bus_state_r == BUS_ACK) && avs_write
                        && (avs_address == `MAP_BYTE_ADDR);
    assign cpu_map_wr = cpu_write && dif.reg_hit
                        && (dif.reg_offset == `MAP_REG_INDEX);
    assign map_acc    = allow && (avs_map_wr || cpu_map_wr);

    // Next placement, window counter and write-once flag
    always_comb begin
        map_nxt     = map_r;
        written_nxt = written_r;
        cnt_nxt     = win_open ? cnt_r + 7'h01 : cnt_r;
        if (map_acc) begin
            written_nxt = 1'b1;
            map_nxt     = avs_map_wr ? avs_writedata[7:0] : cpu_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            map_r     <= `MAP_RESET;
            written_r <= 1'b0;
            cnt_r     <= 7'h00;
        end else begin
            map_r     <= map_nxt;
            written_r <= written_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    // ============================================================
    // Avalon slave: one wait cycle, then answer
    always_comb begin
        status = 32'h0000_0000;
        status[`STAT_WRITTEN_BIT] = written_r;
        status[`STAT_OPEN_BIT]    = allow;
        status[`STAT_SPECIAL_BIT] = mode_special;
    end

    always_comb begin
        bus_state_nxt = BUS_IDLE;
        rdata_nxt     = rdata_r;
        unique case (bus_state_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_nxt = BUS_ACK;
                    if (avs_address == `MAP_BYTE_ADDR) begin
                        rdata_nxt = {24'h00_0000, map_r};
                    end else if (avs_address == `STAT_BYTE_ADDR) begin
                        rdata_nxt = status;
                    end else begin
                        rdata_nxt = 32'h0000_0000;
                    end
                end
            end
            BUS_ACK: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = (avs_read || avs_write)
                             && (bus_state_r != BUS_ACK);
    assign avs_readdata    = rdata_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state_r <= BUS_IDLE;
            rdata_r     <= 32'h0000_0000;
        end else begin
            bus_state_r <= bus_state_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ============================================================
    // CPU data path: RAM storage and registered read data
    always_comb begin
        cpu_rdata_nxt = 8'h00;
        if (dif.ram_hit) begin
            cpu_rdata_nxt = mem[dif.ram_index];
        end else if (cpu_map_wr == 1'b0 && dif.reg_hit
                     && dif.reg_offset == `MAP_REG_INDEX) begin
            cpu_rdata_nxt = map_r;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_rdata_r <= 8'h00;
        end else begin
            cpu_rdata_r <= cpu_rdata_nxt;
        end
    end

    // RAM array keeps contents across reset
    always_ff @(posedge core_clk) begin
        if (cpu_write && dif.ram_hit) begin
            mem[dif.ram_index] <= cpu_wdata;
        end
    end

    assign cpu_rdata = cpu_rdata_r;

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    reset_map_a: assert property (
        !written_r |-> map_r == 8'h00)
        else $error("placement changed without an accepted write");

    ram_index_a: assert property (
        dif.ram_hit |-> dif.ram_index < 10'h300)
        else $error("RAM index beyond array");

    ram_place_a: assert property (
        (cpu_addr[15:12] == map_r[7:4] && !dif.reg_hit
         && cpu_addr[11:0] < 12'h300)
        |-> dif.ram_hit && dif.ram_index == cpu_addr[9:0])
        else $error("RAM not decoded at its page");

    reloc_hit_a: assert property (
        (map_r[7:4] == map_r[3:0] && cpu_addr[15:12] == map_r[7:4]
         && cpu_addr[11:0] >= 12'h300 && cpu_addr[11:0] <= 12'h37F)
        |-> dif.ram_hit
            && dif.ram_index == {3'b000, cpu_addr[6:0]})
        else $error("covered RAM bytes not relocated");

    reg_place_a: assert property (
        dif.reg_hit == (cpu_addr[15:12] == map_r[3:0]
                        && cpu_addr[11:7] == 5'h00))
        else $error("register block decoded at wrong place");

    map_change_a: assert property (
        !$stable(map_r) |-> $past(avs_map_wr || cpu_map_wr))
        else $error("placement changed without a write");

    write_once_a: assert property (
        (!mode_special && (written_r || !win_open)
         && (avs_map_wr || cpu_map_wr))
        |=> map_r == $past(map_r))
        else $error("late or second write taken in normal mode");

    window_len_a: assert property (
        $rose(cnt_r == 7'h40) |-> $past(cnt_r) == 7'h3F)
        else $error("write window length wrong");

    reg_wins_a: assert property (
        dif.reg_hit |-> !dif.ram_hit)
        else $error("RAM and registers both selected");

    bus_ack_a: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");

    reloc_c: cover property (dif.ram_hit && cpu_addr[11:0] >= 12'h300);
    accept_c: cover property (map_acc && !mode_special);
    refuse_c: cover property (avs_map_wr && !allow);
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the RAM and register block address map
`timescale 1ns/1ps
`include "amap_map.svh"
module tb_top;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        mode_special = 1'b0;
    logic [8:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] cpu_addr = '0;
    logic        cpu_write = 1'b0;
    logic [7:0]  cpu_wdata = '0;
    logic [7:0]  cpu_rdata;
    logic        cpu_ram_hit;
    logic        cpu_reg_hit;
    logic [6:0]  cpu_reg_offset;
    int          mismatches = 0;
    int          compares = 0;
    logic [11:0] offs [6] = '{12'h07F, 12'h080, 12'h2FF,
                              12'h300, 12'h37F, 12'h380};

    ram_reg_map uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .mode_special(mode_special), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_addr(cpu_addr),
        .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_ram_hit(cpu_ram_hit),
        .cpu_reg_hit(cpu_reg_hit), .cpu_reg_offset(cpu_reg_offset));

    // Clock, 8 ns period
    always #4 core_clk = ~core_clk;

    // ============================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask

    // Avalon cycle: hold until waitrequest seen low at a rising edge
    task automatic avm(input logic wr, input logic [8:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge core_clk);
        while (avs_waitrequest && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) mismatches++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_write <= 1'b1;
        @(posedge core_clk);
        cpu_write <= 1'b0;
    endtask

    task automatic cpu_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        cpu_addr <= a;
        repeat (2) @(posedge core_clk);
        d = cpu_rdata;
    endtask

    // Expected {ram hit, register hit} for an address and placement
    function automatic logic [1:0] exp_dec(input logic [15:0] a,
                                           input logic [7:0] p);
        logic rg;
        logic rm;
        rg = (a[15:12] == p[3:0]) && (a[11:7] == 5'h00);
        if (p[7:4] == p[3:0]) rm = !rg && a[11:0] <= 12'h37F;
        else rm = a[11:0] < 12'h300;
        return {rm && a[15:12] == p[7:4], rg};
    endfunction

    task automatic dec_chk(input logic [15:0] a, input logic [7:0] p);
        logic [1:0] e;
        e = exp_dec(a, p);
        @(posedge core_clk);
        cpu_addr <= a;
        @(posedge core_clk);
        chk(32'(cpu_ram_hit), 32'(e[1]));
        chk(32'(cpu_reg_hit), 32'(e[0]));
        if (e[0]) chk(32'(cpu_reg_offset), 32'(a[6:0]));
    endtask

    // ============================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [7:0]  p;
        logic [7:0]  d;
        logic [7:0]  q;
        logic [15:0] a;
        void'($urandom(94449));
        do_reset;
        avm(1'b0, `MAP_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0000);
        for (int j = 0; j < 6; j++) dec_chk({4'h0, offs[j]}, 8'h00);
        cpu_wr(16'h0300, 8'hA5);
        cpu_wr(16'h0080, 8'h5A);
        cpu_rd(16'h0300, q);
        chk(32'(q), 32'h0000_00A5);
        // Normal mode: first write in window sticks, second ignored
        avm(1'b1, `MAP_BYTE_ADDR, 32'h0000_0021, r);
        avm(1'b1, `MAP_BYTE_ADDR, 32'h0000_0043, r);
        avm(1'b0, `MAP_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0021);
        avm(1'b0, `STAT_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0001);
        for (int j = 0; j < 12; j++)
            dec_chk({j[0] ? 4'h2 : 4'h1, offs[j / 2]}, 8'h21);
        cpu_rd(16'h103D, q);
        chk(32'(q), 32'h0000_0021);
        cpu_rd(16'h2000, q);
        chk(32'(q), 32'h0000_00A5);
        cpu_rd(16'h2080, q);
        chk(32'(q), 32'h0000_005A);
        // Last window cycle still accepts, the next one refuses
        do_reset;
        repeat (61) @(posedge core_clk);
        avm(1'b1, `MAP_BYTE_ADDR, 32'h0000_0012, r);
        avm(1'b0, `MAP_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0012);
        do_reset;
        repeat (62) @(posedge core_clk);
        avm(1'b1, `MAP_BYTE_ADDR, 32'h0000_0055, r);
        cpu_wr(16'h003D, 8'h77);
        avm(1'b0, `MAP_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0000);
        avm(1'b0, `STAT_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0000);
        avm(1'b1, 9'h004, 32'h0000_00FF, r);
        avm(1'b0, 9'h004, '0, r);
        chk(r, 32'h0000_0000);
        // Special mode: repeated placements by both paths
        @(posedge core_clk);
        mode_special <= 1'b1;
        p = 8'h00;
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h33 : 8'($urandom);
            if (i[0]) cpu_wr({p[3:0], 12'h03D}, d);
            else avm(1'b1, `MAP_BYTE_ADDR, 32'(d), r);
            p = d;
            avm(1'b0, `MAP_BYTE_ADDR, '0, r);
            chk(r, 32'(p));
            for (int j = 0; j < 12; j++)
                dec_chk({j[0] ? p[7:4] : p[3:0], offs[j / 2]}, p);
            dec_chk(16'($urandom), p);
            a = {p[7:4], 12'h080 + 12'($urandom_range(0, 12'h27F))};
            d = 8'($urandom);
            cpu_wr(a, d);
            cpu_rd(a, q);
            chk(32'(q), 32'(d));
        end
        cpu_wr({p[3:0], 12'h03C}, 8'hFF);
        avm(1'b0, `MAP_BYTE_ADDR, '0, r);
        chk(r, 32'(p));
        avm(1'b0, `STAT_BYTE_ADDR, '0, r);
        chk(r, 32'h0000_0007);
        close_out;
    end

    // Watchdog against a hung handshake
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule
